/* File: hw/acs_pkg.sv */
// Package for the converter scan configuration block
package acs_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h0;
	localparam logic [3:0] ADDR_SCAN_HIGH = 4'h1;
	localparam logic [3:0] ADDR_SCAN_LOW = 4'h2;
	localparam logic [3:0] ADDR_MODE = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int REF_LSB = 13;
	localparam int OFFSET_CALIBRATION_BIT = 12;
	localparam int SCAN_BIT = 10;
	localparam int CHSEL_LSB = 8;
	localparam int FILL_BIT = 7;
	localparam int SPLIT_BIT = 1;
	localparam int ALT_BIT = 0;
	localparam int MODE_TWELVE_BIT = 0;
	localparam int MODE_SECOND_INST_BIT = 1;
	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hF77F;
	localparam logic [15:0] SCAN_RESET = 16'h0000;
	localparam logic [15:0] OPAMP_RESET = 16'h0000;
	// Reference codes
	localparam logic [2:0] REF_SUPPLY = 3'h0;
	localparam logic [2:0] REF_EXT_POS = 3'h1;
	localparam logic [2:0] REF_EXT_NEG = 3'h2;
	localparam logic [2:0] REF_EXT_BOTH = 3'h3;
	// Interrupt status bits and scan sequence length
	localparam int IRQ_HALF_DONE = 0;
	localparam int IRQ_SCAN_WRAP = 1;
	localparam int SEQ_SLOTS = 32;
endpackage

/* File: hw/acs_scan_config.sv */
// Converter control two, input scan selection and sequencing control
//
// Behaviour
// - Second instance ignores external reference codes
// - Offset calibration ties both inputs to ground
// - Scan bit scans channel zero positive input
// - Channel select picks one, two or four channels
// - Channel select reads zero in twelve-bit mode
// - Fill status shows half being filled
// - Scan bit includes or skips its input
// - Missing scanned input converts low reference
// - Op amp mode selects op amp output
`timescale 1ns/100ps
module acs_scan_config #(
	parameter int NUM_INPUTS = 32,
	parameter logic [31:0] PRESENT_INPUTS = 32'hFFFF_FFFF,
	parameter logic [31:0] OPAMP_SHARED = 32'h0000_0000,
	parameter int HALF_SAMPLES = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	input wire logic [NUM_INPUTS-1:0] op_amp_mode,
	input wire logic conv_done,
	output logic [2:0] ref_high_sel,
	output logic [2:0] ref_low_sel,
	output logic short_inputs,
	output logic [3:0] chan_enable,
	output logic [4:0] sample_mux_a_sel,
	output logic sample_mux_a_is_opamp,
	output logic sample_mux_a_is_low_ref,
	output logic irq
);
	import acs_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] ctrl_r, ctrl_nxt;
	logic [15:0] scan_hi_r, scan_lo_r;
	logic [1:0] mode_r;
	logic [1:0] stat_r, stat_nxt;
	logic [1:0] mask_r;
	logic fill_r, fill_nxt;
	logic [4:0] slot_r, slot_nxt;
	logic [$clog2(HALF_SAMPLES+1)-1:0] cnt_r, cnt_nxt;
	logic [15:0] rdata_r;

	wire twelve_bit = mode_r[MODE_TWELVE_BIT];
	wire second_inst = mode_r[MODE_SECOND_INST_BIT];
	wire [31:0] scan_all = {scan_hi_r, scan_lo_r};
	wire [2:0] ref_code = ctrl_r[REF_LSB+:3];
	wire split_mode = ctrl_r[SPLIT_BIT];
	wire scan_on = ctrl_r[SCAN_BIT];
	wire [1:0] chsel = twelve_bit ? 2'h0 : ctrl_r[CHSEL_LSB+:2];

	// ----------------------------------------
	// Reference selection, input short and channel enables
	// ----------------------------------------
	// Codes 001..011 fall back to supply on the second instance
	wire [2:0] ref_eff = (second_inst && ref_code >= REF_EXT_POS && ref_code <= REF_EXT_BOTH)
		? REF_SUPPLY : ref_code;
	// 0 = analog supply/ground, 1 = external reference pin
	assign ref_high_sel = {2'h0, (ref_eff == REF_EXT_POS || ref_eff == REF_EXT_BOTH)};
	assign ref_low_sel = {2'h0, (ref_eff == REF_EXT_NEG || ref_eff == REF_EXT_BOTH)};
	assign short_inputs = ctrl_r[OFFSET_CALIBRATION_BIT];
	assign chan_enable = chsel[1] ? 4'hF : (chsel[0] ? 4'h3 : 4'h1);

	// ----------------------------------------
	// Scan sequencer
	// ----------------------------------------
	function automatic logic [4:0] next_slot(input logic [4:0] cur, input logic [31:0] sel);
		logic [4:0] res;
		logic found;
		res = cur;
		found = 1'b0;
		for (int i = 1; i <= SEQ_SLOTS; i++) begin
			if (!found && sel[5'(cur + 5'(i))]) begin
				res = 5'(cur + 5'(i));
				found = 1'b1;
			end
		end
		return res;
	endfunction

	wire [4:0] slot_next_sel = next_slot(slot_r, scan_all);
	wire wrap = scan_on && conv_done && (slot_next_sel <= slot_r);
	assign sample_mux_a_sel = scan_on ? slot_r : 5'h00;
	assign sample_mux_a_is_low_ref = scan_on && !PRESENT_INPUTS[slot_r];
	assign sample_mux_a_is_opamp = scan_on && PRESENT_INPUTS[slot_r]
		&& OPAMP_SHARED[slot_r] && op_amp_mode[slot_r];
	assign slot_nxt = (scan_on && conv_done) ? slot_next_sel : slot_r;

	// ----------------------------------------
	// Split buffer fill tracking
	// ----------------------------------------
	wire half_done = split_mode && conv_done && (cnt_r == ($bits(cnt_r))'(HALF_SAMPLES - 1));
	assign cnt_nxt = !split_mode ? '0 : (conv_done ? (half_done ? '0 : cnt_r + 1'b1) : cnt_r);
	assign fill_nxt = !split_mode ? 1'b0 : (half_done ? ~fill_r : fill_r);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	wire wr_ctrl = wr_en && addr == ADDR_CTRL_TWO;
	wire rd_stat = rd_en && addr == ADDR_IRQ_STAT;
	assign ctrl_nxt = wr_ctrl ? (wdata & CTRL_WMASK) : ctrl_r;
	wire [1:0] events = {wrap, half_done};
	// Set wins over read-to-clear
	assign stat_nxt = events | (rd_stat ? 2'h0 : stat_r);
	wire [15:0] ctrl_view = {ctrl_r[15:10], chsel, fill_r, ctrl_r[6:0]};
	logic [15:0] rd_mux;
	always_comb begin
		if (addr == ADDR_CTRL_TWO) begin
			rd_mux = ctrl_view;
		end else if (addr == ADDR_SCAN_HIGH) begin
			rd_mux = scan_hi_r;
		end else if (addr == ADDR_SCAN_LOW) begin
			rd_mux = scan_lo_r;
		end else if (addr == ADDR_MODE) begin
			rd_mux = {14'h0, mode_r};
		end else if (addr == ADDR_IRQ_STAT) begin
			rd_mux = {14'h0, stat_r};
		end else if (addr == ADDR_IRQ_MASK) begin
			rd_mux = {14'h0, mask_r};
		end else begin
			rd_mux = 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= CTRL_RESET;
			scan_hi_r <= SCAN_RESET;
			scan_lo_r <= SCAN_RESET;
			mode_r <= 2'h0;
			mask_r <= 2'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			if (wr_en && addr == ADDR_SCAN_HIGH) scan_hi_r <= wdata;
			if (wr_en && addr == ADDR_SCAN_LOW) scan_lo_r <= wdata;
			if (wr_en && addr == ADDR_MODE) mode_r <= wdata[1:0];
			if (wr_en && addr == ADDR_IRQ_MASK) mask_r <= wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stat_r <= 2'h0;
			fill_r <= 1'b0;
			slot_r <= 5'h00;
			cnt_r <= '0;
			rdata_r <= 16'h0000;
		end else begin
			stat_r <= stat_nxt;
			fill_r <= fill_nxt;
			slot_r <= slot_nxt;
			cnt_r <= cnt_nxt;
			rdata_r <= rd_en ? rd_mux : 16'h0000;
		end
	end

	assign rdata = rdata_r;
	assign irq = |(stat_r & mask_r);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_short_follows: assert property (@(posedge clk) disable iff (!rstn)
		short_inputs == ctrl_r[OFFSET_CALIBRATION_BIT]) else $error("short mismatch");
	a_ref_second_inst: assert property (@(posedge clk) disable iff (!rstn)
		second_inst |-> (ref_high_sel == 3'h0 && ref_low_sel == 3'h0)) else $error("ext ref on inst2");
	a_ref_ext_pos: assert property (@(posedge clk) disable iff (!rstn)
		(!second_inst && ref_code == REF_EXT_POS) |-> (ref_high_sel == 3'h1 && ref_low_sel == 3'h0))
		else $error("ref pos wrong");
	a_chan_twelve: assert property (@(posedge clk) disable iff (!rstn)
		twelve_bit |-> (chan_enable == 4'h1 && ctrl_view[9:8] == 2'h0)) else $error("chsel in 12b");
	a_chan_four: assert property (@(posedge clk) disable iff (!rstn)
		(!twelve_bit && ctrl_r[9]) |-> chan_enable == 4'hF) else $error("chan four");
	a_fill_toggle: assert property (@(posedge clk) disable iff (!rstn)
		half_done |=> fill_r != $past(fill_r)) else $error("fill no toggle");
	a_fill_clear: assert property (@(posedge clk) disable iff (!rstn)
		!split_mode |=> !fill_r) else $error("fill outside split");
	a_scan_idle: assert property (@(posedge clk) disable iff (!rstn)
		!scan_on |-> (sample_mux_a_sel == 5'h00 && !sample_mux_a_is_low_ref)) else $error("scan idle");
	a_scan_skip: assert property (@(posedge clk) disable iff (!rstn)
		(scan_on && conv_done && |scan_all) |=> scan_all[slot_r]) else $error("skipped input");
	a_opamp_sel: assert property (@(posedge clk) disable iff (!rstn)
		sample_mux_a_is_opamp |-> op_amp_mode[slot_r]) else $error("opamp sel");

	// ----------------------------------------
	// Sequences of the multi-step checks
	// ----------------------------------------
	sequence s_ctrl_write;
		wr_en && addr == ADDR_CTRL_TWO;
	endsequence
	sequence s_stat_read;
		rd_en && addr == ADDR_IRQ_STAT;
	endsequence
	sequence s_scan_conv;
		scan_on && conv_done;
	endsequence
	sequence s_half_end;
		split_mode && conv_done && cnt_r == ($bits(cnt_r))'(HALF_SAMPLES - 1);
	endsequence
	sequence s_quiet_events;
		!half_done && !wrap;
	endsequence

	// Control write lands through the writable mask
	property p_ctrl_lands;
		@(posedge clk) disable iff (!rstn)
		s_ctrl_write |=> ctrl_r == ($past(wdata) & CTRL_WMASK);
	endproperty

	// Scan moves to the next selected slot
	property p_scan_step;
		@(posedge clk) disable iff (!rstn)
		s_scan_conv |=> slot_r == $past(slot_next_sel);
	endproperty

	// Last sample of a half restarts the count and flags it
	property p_half_restart;
		@(posedge clk) disable iff (!rstn)
		s_half_end |=> (cnt_r == '0 && stat_r[IRQ_HALF_DONE]);
	endproperty

	// Status read with no event clears every bit
	property p_stat_clears;
		@(posedge clk) disable iff (!rstn)
		(s_stat_read ##0 s_quiet_events) |=> stat_r == 2'h0;
	endproperty

	// An event in the cycle of the read still sets
	property p_set_beats_clear;
		@(posedge clk) disable iff (!rstn)
		(s_stat_read ##0 s_half_end) |=> stat_r[IRQ_HALF_DONE];
	endproperty

	// Wrap of the scan flags its status bit
	property p_wrap_flag;
		@(posedge clk) disable iff (!rstn)
		(s_scan_conv ##0 wrap) |=> stat_r[IRQ_SCAN_WRAP];
	endproperty

	// Read data stand one cycle after the strobe
	property p_read_answer;
		@(posedge clk) disable iff (!rstn)
		rd_en |=> rdata == $past(rd_mux);
	endproperty

	// Read data idle at zero otherwise
	property p_read_idle;
		@(posedge clk) disable iff (!rstn)
		!rd_en |=> rdata == 16'h0000;
	endproperty

	// ----------------------------------------
	// Register bus and interrupt checks
	// ----------------------------------------
	a_ctrl_write: assert property (p_ctrl_lands)
		else $error("control write lost");
	a_read_answer: assert property (p_read_answer)
		else $error("read data wrong");
	a_read_idle: assert property (p_read_idle)
		else $error("read data not idle");
	a_stat_clear: assert property (p_stat_clears)
		else $error("status not cleared");
	a_set_wins: assert property (p_set_beats_clear)
		else $error("event lost to clear");
	a_wrap_flag: assert property (p_wrap_flag)
		else $error("wrap flag missing");
	a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
		(stat_r & mask_r) != 2'h0 |-> irq) else $error("irq low");
	a_scan_high_write: assert property (@(posedge clk) disable iff (!rstn)
		(wr_en && addr == ADDR_SCAN_HIGH) |=> scan_hi_r == $past(wdata))
		else $error("scan high write lost");
	a_scan_low_write: assert property (@(posedge clk) disable iff (!rstn)
		(wr_en && addr == ADDR_SCAN_LOW) |=> scan_lo_r == $past(wdata))
		else $error("scan low write lost");
	a_mode_write: assert property (@(posedge clk) disable iff (!rstn)
		(wr_en && addr == ADDR_MODE) |=> {14'h0000, mode_r} == ($past(wdata) & 16'h0003))
		else $error("mode write lost");
	a_mask_write: assert property (@(posedge clk) disable iff (!rstn)
		(wr_en && addr == ADDR_IRQ_MASK) |=> {14'h0000, mask_r} == ($past(wdata) & 16'h0003))
		else $error("mask write lost");

	// ----------------------------------------
	// Reference and channel checks
	// ----------------------------------------
	a_ref_supply: assert property (@(posedge clk) disable iff (!rstn)
		ref_code == REF_SUPPLY |-> (ref_high_sel == 3'h0 && ref_low_sel == 3'h0))
		else $error("ref supply wrong");
	a_ref_ext_neg: assert property (@(posedge clk) disable iff (!rstn)
		(!second_inst && ref_code == REF_EXT_NEG)
		|-> (ref_high_sel == 3'h0 && ref_low_sel == 3'h1))
		else $error("ref neg wrong");
	a_ref_both: assert property (@(posedge clk) disable iff (!rstn)
		(!second_inst && ref_code == REF_EXT_BOTH)
		|-> (ref_high_sel == 3'h1 && ref_low_sel == 3'h1))
		else $error("ref both wrong");
	a_ref_inst_two: assert property (@(posedge clk) disable iff (!rstn)
		(second_inst && ref_code == REF_EXT_BOTH) |-> ref_high_sel == 3'h0)
		else $error("ext ref both on inst2");
	a_offset_calibration_set: assert property (@(posedge clk) disable iff (!rstn)
		ctrl_r[OFFSET_CALIBRATION_BIT] |-> short_inputs)
		else $error("inputs not shorted");
	a_offset_calibration_clear: assert property (@(posedge clk) disable iff (!rstn)
		!ctrl_r[OFFSET_CALIBRATION_BIT] |-> !short_inputs)
		else $error("inputs shorted");
	a_chan_one: assert property (@(posedge clk) disable iff (!rstn)
		(!twelve_bit && ctrl_r[9:8] == 2'h0) |-> chan_enable == 4'h1)
		else $error("chan one");
	a_chan_two: assert property (@(posedge clk) disable iff (!rstn)
		(!twelve_bit && ctrl_r[9:8] == 2'h1) |-> chan_enable == 4'h3)
		else $error("chan two");
	a_chan_view: assert property (@(posedge clk) disable iff (!rstn)
		!twelve_bit |-> ctrl_view[9:8] == ctrl_r[9:8])
		else $error("chsel view");
	a_gap_bit: assert property (@(posedge clk) disable iff (!rstn)
		ctrl_view[11] == 1'b0)
		else $error("gap bit set");

	// ----------------------------------------
	// Scan and fill checks
	// ----------------------------------------
	a_scan_step: assert property (p_scan_step)
		else $error("scan step wrong");
	a_scan_hold: assert property (@(posedge clk) disable iff (!rstn)
		(!scan_on || !conv_done) |=> slot_r == $past(slot_r))
		else $error("scan moved");
	a_low_ref: assert property (@(posedge clk) disable iff (!rstn)
		(scan_on && !PRESENT_INPUTS[slot_r]) |-> (sample_mux_a_is_low_ref && !sample_mux_a_is_opamp))
		else $error("low ref missing");
	a_opamp_off: assert property (@(posedge clk) disable iff (!rstn)
		(scan_on && !op_amp_mode[slot_r]) |-> !sample_mux_a_is_opamp)
		else $error("opamp without mode");
	a_pin_path: assert property (@(posedge clk) disable iff (!rstn)
		(scan_on && PRESENT_INPUTS[slot_r] && !OPAMP_SHARED[slot_r]) |-> !sample_mux_a_is_opamp)
		else $error("pin path wrong");
	a_half_restart: assert property (p_half_restart)
		else $error("half restart wrong");
	a_fill_hold: assert property (@(posedge clk) disable iff (!rstn)
		(split_mode && !half_done) |=> fill_r == $past(fill_r))
		else $error("fill moved");
	a_fill_view: assert property (@(posedge clk) disable iff (!rstn)
		ctrl_view[FILL_BIT] == fill_r)
		else $error("fill view");
endmodule // acs_scan_config

/* File: test/acs_front_model.sv */
// Model of the analog front end that reports finished conversions
`timescale 1ns/100ps
module acs_front_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic go,
	input wire logic [2:0] dly,
	output logic conv_done
);
	logic [3:0] cnt_r;
	// Each request ends in one done pulse, dly+1 cycles later
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 4'h0;
			conv_done <= 1'b0;
		end else begin
			conv_done <= !go && (cnt_r == 4'h1);
			cnt_r <= go ? {1'b0, dly} + 4'h1 : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
		end
	end
endmodule // acs_front_model

/* File: test/test_adc_channel_scan_config.sv */
// Self-checking bench for the scan configuration block
`timescale 1ns/100ps
module test_adc_channel_scan_config;
	import acs_pkg::*;
	logic clk = 0, rstn = 0, wr_en = 0, rd_en = 0, go = 0, rd_q = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [31:0] op_amp_mode;
	logic [2:0] dly = 3'h0, ref_high_sel, ref_low_sel;
	logic [3:0] chan_enable;
	logic [4:0] sel;
	logic conv_done, short_inputs, is_op, is_lr, irq;
	logic [15:0] q[$];
	int seed = 29, n_errors = 0, checks = 0;
	int sq[4] = '{0, 2, 16, 0};
	always #20 clk = ~clk;
	acs_scan_config #(.PRESENT_INPUTS(32'h0000_FFFF), .OPAMP_SHARED(32'h0000_0004)) u_dut (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .op_amp_mode(op_amp_mode), .conv_done(conv_done),
		.ref_high_sel(ref_high_sel), .ref_low_sel(ref_low_sel), .short_inputs(short_inputs),
		.chan_enable(chan_enable), .sample_mux_a_sel(sel), .sample_mux_a_is_opamp(is_op),
		.sample_mux_a_is_low_ref(is_lr), .irq(irq));
	acs_front_model u_fe (.clk(clk), .rstn(rstn), .go(go), .dly(dly), .conv_done(conv_done));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{wr_en, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		{rd_en, addr} <= {1'b1, a};
		q.push_back(e);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask
	task conv();
		@(posedge clk);
		go <= 1'b1;
		dly <= 3'($random(seed));
		@(posedge clk);
		go <= 1'b0;
		repeat (12) begin
			@(posedge clk);
			if (conv_done === 1'b1)
				break;
		end
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) rd_q <= rd_en;
	always @(negedge clk) if (rd_q) chk(rdata, q.pop_front());
	task give_verdict();
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#400000;
		n_errors++;
		give_verdict();
	end
	initial begin
		op_amp_mode <= $random(seed);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(ADDR_CTRL_TWO, 16'h0000);
		chk(chan_enable, 16'h0001);
		wr(ADDR_CTRL_TWO, 16'hFFFF);
		rd(ADDR_CTRL_TWO, 16'hF77F);
		@(negedge clk) chk(short_inputs, 1);
		wr(ADDR_MODE, 16'h0001);
		rd(ADDR_CTRL_TWO, 16'hF47F);
		rd(4'hF, 16'h0000);
		for (int m = 0; m < 4; m += 2) begin
			wr(ADDR_MODE, 16'(m));
			for (int c = 0; c < 4; c++) begin
				wr(ADDR_CTRL_TWO, 16'(c << REF_LSB) | 16'(c << CHSEL_LSB));
				@(negedge clk) chk(short_inputs, 0);
				chk({ref_low_sel[0], ref_high_sel[0]}, m ? 0 : 16'(c));
				if (m == 0)
					chk(chan_enable, c == 0 ? 1 : c == 1 ? 3 : 15);
			end
		end
		wr(ADDR_MODE, 16'h0000);
		wr(ADDR_CTRL_TWO, 16'h0002);
		for (int h = 1; h <= 2; h++) begin
			repeat (8) conv();
			rd(ADDR_CTRL_TWO, h == 1 ? 16'h0082 : 16'h0002);
		end
		@(negedge clk) chk(irq, 0);
		wr(ADDR_IRQ_MASK, 16'h0001);
		@(negedge clk) chk(irq, 1);
		rd(ADDR_IRQ_STAT, 16'h0001);
		@(negedge clk) chk(irq, 0);
		wr(ADDR_SCAN_LOW, 16'h0005);
		wr(ADDR_SCAN_HIGH, 16'h0001);
		wr(ADDR_CTRL_TWO, 16'h0400);
		foreach (sq[i]) begin
			@(negedge clk) chk(sel, 16'(sq[i]));
			if (sq[i] == 2)
				chk(is_op, op_amp_mode[2]);
			if (sq[i] == 16)
				chk(is_lr, 1);
			conv();
		end
		rd(ADDR_IRQ_STAT, 16'h0002);
		repeat (2) @(posedge clk);
		give_verdict();
	end
endmodule // test_adc_channel_scan_config
